// file: verilog/blc_regs.svh
// constants of the brightness command handler: codes, defaults, limits
// assumes inclusion by every blc design file that decodes frames
`ifndef BLC_REGS_SVH
`define BLC_REGS_SVH

// lead codes
`define BLC_LEAD_CMD        8'h07
`define BLC_LEAD_ACK        8'h06
`define BLC_LEAD_NAK        8'h15

// command bytes
`define BLC_GRP_B0          8'h42
`define BLC_GRP_B1          8'h52
`define BLC_CMD_FLOOR       8'h49
`define BLC_CMD_CEILING     8'h4D
`define BLC_CMD_GLOBAL      8'h54
`define BLC_CMD_KEYPAD      8'h4C
`define BLC_MENU_B0         8'h4D
`define BLC_MENU_B1         8'h43
`define BLC_MENU_B2         8'h43

// menu sub-mode characters
`define BLC_MENU_QUERY      8'h3F
`define BLC_MENU_RESET_UC   8'h52
`define BLC_MENU_RESET_LC   8'h72
`define BLC_MENU_INC        8'h2B
`define BLC_MENU_DEC        8'h2D

// checks, address, defaults
`define BLC_CHK_GOOD        8'hFF
`define BLC_ADDR_BROADCAST  8'hFF
`define BLC_LEVEL_DEFAULT   8'hFF
`define BLC_LEVEL_MAX       8'hFF
`define BLC_LEVEL_MIN       8'h00
`define BLC_FOLLOW_BACKLT   8'hFF
`define BLC_PAYLOAD_MAX     8'h4A
`define BLC_USER_FULL_SCALE 16'h00FF

`endif

// file: verilog/blc_pkg.sv
// types shared by the brightness command handler modules
// assumes nothing beyond a SystemVerilog compiler
package blc_pkg;

   typedef enum logic [3:0] {
      RX_LEAD = 4'h0,
      RX_ADDR = 4'h1,
      RX_CMD0 = 4'h2,
      RX_CMD1 = 4'h3,
      RX_CMD2 = 4'h4,
      RX_LEN  = 4'h5,
      RX_HCHK = 4'h6,
      RX_DATA = 4'h7,
      RX_DCHK = 4'h8
   } blc_rx_state_type;

   typedef enum logic [2:0] {
      SEL_FLOOR   = 3'h0,
      SEL_CEILING = 3'h1,
      SEL_GLOBAL  = 3'h2,
      SEL_KEYPAD  = 3'h3,
      SEL_MENU    = 3'h4,
      SEL_NONE    = 3'h5
   } blc_sel_type;

endpackage : blc_pkg

// file: verilog/blc_reply_if.sv
// reply request carrier between the command decoder and the reply sender
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
interface blc_reply_if;
   logic       start;
   logic [7:0] lead;
   logic [7:0] addr;
   logic [7:0] cmd0;
   logic [7:0] cmd1;
   logic [7:0] cmd2;
   logic       has_data;
   logic [7:0] data;
   logic       busy;

   modport src (output start, lead, addr, cmd0, cmd1, cmd2, has_data, data, input busy);
   modport snk (input start, lead, addr, cmd0, cmd1, cmd2, has_data, data, output busy);
endinterface : blc_reply_if

// file: verilog/blc_reply_tx.sv
// reply frame sender: builds and shifts out an ack or nak frame
// assumes a byte sink with valid/ready on the same clock
`timescale 1ns/100ps
`include "blc_regs.svh"
module blc_reply_tx
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   // request side
   blc_reply_if.snk        req,
   // byte sink
   output logic [7:0]      tx_byte_out,
   output logic            tx_valid_out,
   input  wire logic       tx_ready_in
);
   logic [7:0] frame_r [0:8];
   logic [3:0] idx_r;
   logic [3:0] last_r;
   logic       busy_r;
   wire  [7:0] len_byte = req.has_data ? 8'h01 : 8'h00;
   wire  [7:0] hsum     = 8'(req.lead + req.addr + req.cmd0 + req.cmd1 + req.cmd2 + len_byte);
   wire        take     = req.start && !busy_r;
   wire        shift    = busy_r && tx_ready_in;

   assign req.busy     = busy_r;
   assign tx_valid_out = busy_r;
   assign tx_byte_out  = frame_r[idx_r];

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         busy_r <= 1'b0;
         idx_r  <= 4'h0;
         last_r <= 4'h0;
      end
      else if (take)
      begin
         busy_r <= 1'b1;
         idx_r  <= 4'h0;
         last_r <= req.has_data ? 4'h8 : 4'h6;
      end
      else if (shift)
      begin
         busy_r <= (idx_r != last_r);
         idx_r  <= (idx_r == last_r) ? 4'h0 : idx_r + 4'h1;
      end
   end

   // frame image; both checks recomputed here
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         for (int i = 0; i < 9; i++)
            frame_r[i] <= 8'h00;
      end
      else if (take)
      begin
         frame_r[0] <= req.lead;
         frame_r[1] <= req.addr;
         frame_r[2] <= req.cmd0;
         frame_r[3] <= req.cmd1;
         frame_r[4] <= req.cmd2;
         frame_r[5] <= len_byte;
         frame_r[6] <= ~hsum;
         frame_r[7] <= req.data;
         frame_r[8] <= ~req.data;
      end
   end
endmodule : blc_reply_tx

// file: verilog/blc_bright_calc.sv
// visible backlight and keypad led drive from the stored levels
// assumes level inputs already settled on the same clock
`timescale 1ns/100ps
`include "blc_regs.svh"
module blc_bright_calc
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   // levels
   input  wire logic [7:0] floor_in,
   input  wire logic [7:0] ceiling_in,
   input  wire logic [7:0] global_in,
   input  wire logic [7:0] user_in,
   input  wire logic [7:0] keypad_in,
   input  wire logic [7:0] follow_sel_in,
   // results
   output logic [7:0]      visible_out,
   output logic [7:0]      keypad_drive_out
);
   function automatic logic [7:0] scale(input logic [7:0] span, input logic [7:0] frac);
      logic [15:0] prod;
      prod  = span * frac;
      scale = 8'(prod / `BLC_USER_FULL_SCALE);
   endfunction : scale

   // user steps spread from floor up to global
   wire [7:0] span    = (global_in > floor_in) ? 8'(global_in - floor_in) : 8'h00;
   wire [7:0] mapped  = 8'(floor_in + scale(span, user_in));
   // never below floor nor above ceiling; floor wins if they cross
   wire [7:0] capped  = (mapped > ceiling_in) ? ceiling_in : mapped;
   wire [7:0] bounded = (capped < floor_in) ? floor_in : capped;
   // stored keypad level only used while not tracking backlight
   wire       follow  = (follow_sel_in == `BLC_FOLLOW_BACKLT);

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         visible_out      <= `BLC_LEVEL_MIN;
         keypad_drive_out <= `BLC_LEVEL_MIN;
      end
      else
      begin
         visible_out      <= bounded;
         keypad_drive_out <= follow ? bounded : keypad_in;
      end
   end
endmodule : blc_bright_calc

// file: verilog/blc_backlight_cmd.sv
// brightness command handler: parses framed host commands, keeps levels
// assumes bytes arrive as one-cycle strobes on clk_in, no back-pressure
`timescale 1ns/100ps
`include "blc_regs.svh"
module blc_backlight_cmd
#(
   parameter int unsigned PAYLOAD_LIMIT = 74
)
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   // receive byte strobe
   input  wire logic [7:0] rx_byte_in,
   input  wire logic       rx_valid_in,
   // reply byte sink
   output logic [7:0]      tx_byte_out,
   output logic            tx_valid_out,
   input  wire logic       tx_ready_in,
   // configuration
   input  wire logic [7:0] unit_address_in,
   input  wire logic [7:0] keypad_follow_select_in,
   input  wire logic [7:0] factory_global_in,
   // persistent store
   input  wire logic       stored_valid_in,
   input  wire logic [7:0] stored_floor_in,
   input  wire logic [7:0] stored_ceiling_in,
   input  wire logic [7:0] stored_keypad_in,
   output logic            store_strobe_out,
   output logic [7:0]      store_floor_out,
   output logic [7:0]      store_ceiling_out,
   output logic [7:0]      store_keypad_out,
   // user controls, asynchronous pins
   input  wire logic       knob_input_valid_in,
   input  wire logic [7:0] knob_level_in,
   input  wire logic [7:0] user_level_in,
   // levels and drives
   output logic [7:0]      backlight_floor_out,
   output logic [7:0]      backlight_ceiling_out,
   output logic [7:0]      backlight_global_level_out,
   output logic [7:0]      backlight_user_level_out,
   output logic [7:0]      keypad_led_level_out,
   output logic [7:0]      visible_backlight_out,
   output logic [7:0]      keypad_led_drive_out
);
   // refused at elaboration: the length byte cannot count past 255
   if (PAYLOAD_LIMIT < 1 || PAYLOAD_LIMIT > 255)
   begin : g_limit_check
      $error("PAYLOAD_LIMIT must lie in 1..255");
   end

   localparam logic [7:0] LEN_LIMIT = 8'(PAYLOAD_LIMIT);
   blc_reply_if rep ();

   // receive side state
   blc_pkg::blc_rx_state_type state_r;
   logic [7:0] hsum_r, dsum_r, addr_r, cmd0_r, cmd1_r, cmd2_r, len_r, left_r, data_r;
   logic       exec_r, hdr_ok_r, dat_ok_r;
   // levels
   logic [7:0] floor_r, ceiling_r, global_r, keypad_r;
   logic       load_r, store_r;
   // pin synchronisers
   logic [7:0] knob_s1_r, knob_s2_r, user_s1_r, user_s2_r, user_r;
   logic       kval_s1_r, kval_s2_r;

   // receive decode
   wire [7:0] hsum_nxt = 8'(hsum_r + rx_byte_in);
   wire [7:0] dsum_nxt = 8'(dsum_r + rx_byte_in);
   wire       lead_ok  = (rx_byte_in == `BLC_LEAD_CMD);
   wire       hchk_ok  = (hsum_nxt == `BLC_CHK_GOOD);
   wire       dchk_ok  = (dsum_nxt == `BLC_CHK_GOOD);
   wire       len_ok   = (len_r <= LEN_LIMIT);

   // receiver: other lead codes drop the frame silently
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_r  <= blc_pkg::RX_LEAD;
         hsum_r   <= 8'h00;
         dsum_r   <= 8'h00;
         addr_r   <= 8'h00;
         cmd0_r   <= 8'h00;
         cmd1_r   <= 8'h00;
         cmd2_r   <= 8'h00;
         len_r    <= 8'h00;
         left_r   <= 8'h00;
         data_r   <= 8'h00;
         exec_r   <= 1'b0;
         hdr_ok_r <= 1'b0;
         dat_ok_r <= 1'b0;
      end
      else
      begin
         exec_r <= 1'b0;
         if (rx_valid_in)
         begin
            unique case (state_r)
               blc_pkg::RX_LEAD:
               begin
                  hsum_r  <= rx_byte_in;
                  state_r <= lead_ok ? blc_pkg::RX_ADDR : blc_pkg::RX_LEAD;
               end
               blc_pkg::RX_ADDR:
               begin
                  addr_r  <= rx_byte_in;
                  hsum_r  <= hsum_nxt;
                  state_r <= blc_pkg::RX_CMD0;
               end
               blc_pkg::RX_CMD0:
               begin
                  cmd0_r  <= rx_byte_in;
                  hsum_r  <= hsum_nxt;
                  state_r <= blc_pkg::RX_CMD1;
               end
               blc_pkg::RX_CMD1:
               begin
                  cmd1_r  <= rx_byte_in;
                  hsum_r  <= hsum_nxt;
                  state_r <= blc_pkg::RX_CMD2;
               end
               blc_pkg::RX_CMD2:
               begin
                  cmd2_r  <= rx_byte_in;
                  hsum_r  <= hsum_nxt;
                  state_r <= blc_pkg::RX_LEN;
               end
               blc_pkg::RX_LEN:
               begin
                  len_r   <= rx_byte_in;
                  left_r  <= rx_byte_in;
                  hsum_r  <= hsum_nxt;
                  state_r <= blc_pkg::RX_HCHK;
               end
               blc_pkg::RX_HCHK:
               begin
                  // header sum of bytes 0..6 must land on ff
                  hdr_ok_r <= hchk_ok && len_ok;
                  dat_ok_r <= 1'b1;
                  dsum_r   <= 8'h00;
                  if (hchk_ok && len_ok && len_r != 8'h00)
                     state_r <= blc_pkg::RX_DATA;
                  else
                  begin
                     exec_r  <= 1'b1;
                     state_r <= blc_pkg::RX_LEAD;
                  end
               end
               blc_pkg::RX_DATA:
               begin
                  if (left_r == len_r)
                     data_r <= rx_byte_in;
                  dsum_r  <= dsum_nxt;
                  left_r  <= 8'(left_r - 8'h01);
                  state_r <= (left_r == 8'h01) ? blc_pkg::RX_DCHK : blc_pkg::RX_DATA;
               end
               blc_pkg::RX_DCHK:
               begin
                  dat_ok_r <= dchk_ok;
                  exec_r   <= 1'b1;
                  state_r  <= blc_pkg::RX_LEAD;
               end
               default:
                  state_r <= blc_pkg::RX_LEAD;
            endcase
         end
      end
   end

   // command decode
   wire       grp_bright = (cmd0_r == `BLC_GRP_B0) && (cmd1_r == `BLC_GRP_B1);
   wire       grp_menu   = (cmd0_r == `BLC_MENU_B0) && (cmd1_r == `BLC_MENU_B1)
                           && (cmd2_r == `BLC_MENU_B2);
   blc_pkg::blc_sel_type sel;
   assign sel = !grp_bright && grp_menu              ? blc_pkg::SEL_MENU    :
                !grp_bright                          ? blc_pkg::SEL_NONE    :
                (cmd2_r == `BLC_CMD_FLOOR)           ? blc_pkg::SEL_FLOOR   :
                (cmd2_r == `BLC_CMD_CEILING)         ? blc_pkg::SEL_CEILING :
                (cmd2_r == `BLC_CMD_GLOBAL)          ? blc_pkg::SEL_GLOBAL  :
                (cmd2_r == `BLC_CMD_KEYPAD)          ? blc_pkg::SEL_KEYPAD  :
                                                       blc_pkg::SEL_NONE;

   wire addressed = (addr_r == unit_address_in) || (addr_r == `BLC_ADDR_BROADCAST);
   wire frame_ok  = hdr_ok_r && dat_ok_r;
   wire is_read   = (len_r == 8'h00);
   wire is_write  = (len_r == 8'h01);
   wire is_level  = (sel != blc_pkg::SEL_MENU) && (sel != blc_pkg::SEL_NONE);

   // menu sub-modes
   wire m_query = (data_r == `BLC_MENU_QUERY);
   wire m_reset = (data_r == `BLC_MENU_RESET_UC) || (data_r == `BLC_MENU_RESET_LC);
   wire m_inc   = (data_r == `BLC_MENU_INC);
   wire m_dec   = (data_r == `BLC_MENU_DEC);
   wire m_known = m_query || m_reset || m_inc || m_dec;

   wire level_ok = is_level && (is_read || is_write);
   wire menu_ok  = (sel == blc_pkg::SEL_MENU) && is_write && m_known;
   wire accept   = frame_ok && (level_ok || menu_ok);
   wire act      = exec_r && addressed;
   wire do_write = act && accept && is_level && is_write;
   wire do_menu  = act && accept && (sel == blc_pkg::SEL_MENU);

   wire [7:0] global_inc = (global_r == `BLC_LEVEL_MAX) ? global_r : 8'(global_r + 8'h01);
   wire [7:0] global_dec = (global_r == `BLC_LEVEL_MIN) ? global_r : 8'(global_r - 8'h01);

   // level read back; menu query and steps answer with the global level
   wire [7:0] read_val = (sel == blc_pkg::SEL_FLOOR)   ? floor_r   :
                         (sel == blc_pkg::SEL_CEILING) ? ceiling_r :
                         (sel == blc_pkg::SEL_KEYPAD)  ? keypad_r  :
                         (sel == blc_pkg::SEL_GLOBAL)  ? global_r  :
                         m_inc                         ? global_inc:
                         m_dec                         ? global_dec:
                         m_reset                       ? factory_global_in :
                                                         global_r;

   // reply request; dropped if the sender is still busy
   assign rep.start    = act && !rep.busy;
   assign rep.lead     = accept ? `BLC_LEAD_ACK : `BLC_LEAD_NAK;
   assign rep.addr     = addr_r;
   assign rep.cmd0     = cmd0_r;
   assign rep.cmd1     = cmd1_r;
   assign rep.cmd2     = cmd2_r;
   assign rep.has_data = accept;
   assign rep.data     = (accept && is_write && is_level) ? data_r : read_val;

   // levels: any byte value is legal
   // after reset, one load cycle fetches stored and factory values
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         floor_r   <= `BLC_LEVEL_DEFAULT;
         ceiling_r <= `BLC_LEVEL_DEFAULT;
         keypad_r  <= `BLC_LEVEL_DEFAULT;
         global_r  <= `BLC_LEVEL_DEFAULT;
         load_r    <= 1'b1;
      end
      else if (load_r)
      begin
         load_r    <= 1'b0;
         floor_r   <= stored_valid_in ? stored_floor_in   : `BLC_LEVEL_DEFAULT;
         ceiling_r <= stored_valid_in ? stored_ceiling_in : `BLC_LEVEL_DEFAULT;
         keypad_r  <= stored_valid_in ? stored_keypad_in  : `BLC_LEVEL_DEFAULT;
         global_r  <= factory_global_in;
      end
      else if (do_write)
      begin
         // besides the load cycle, only this path and the menu path touch global
         unique case (sel)
            blc_pkg::SEL_FLOOR:   floor_r   <= data_r;
            blc_pkg::SEL_CEILING: ceiling_r <= data_r;
            blc_pkg::SEL_GLOBAL:  global_r  <= data_r;
            blc_pkg::SEL_KEYPAD:  keypad_r  <= data_r;
            default:              global_r  <= global_r;
         endcase
      end
      else if (do_menu)
      begin
         // factory defaults, or a saturating step of the global level
         if (m_reset)
         begin
            floor_r   <= `BLC_LEVEL_DEFAULT;
            ceiling_r <= `BLC_LEVEL_DEFAULT;
            keypad_r  <= `BLC_LEVEL_DEFAULT;
            global_r  <= factory_global_in;
         end
         else if (m_inc)
            global_r <= global_inc;
         else if (m_dec)
            global_r <= global_dec;
      end
   end

   // persistent levels are pushed to the store; global is power-cleared
   wire store_nxt = (do_write && (sel != blc_pkg::SEL_GLOBAL)) || (do_menu && m_reset);

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         store_r <= 1'b0;
      else
         store_r <= store_nxt;
   end

   // pins pass two flops before use
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         knob_s1_r <= 8'h00;
         knob_s2_r <= 8'h00;
         user_s1_r <= 8'h00;
         user_s2_r <= 8'h00;
         kval_s1_r <= 1'b0;
         kval_s2_r <= 1'b0;
         user_r    <= 8'h00;
      end
      else
      begin
         knob_s1_r <= knob_level_in;
         knob_s2_r <= knob_s1_r;
         user_s1_r <= user_level_in;
         user_s2_r <= user_s1_r;
         kval_s1_r <= knob_input_valid_in;
         kval_s2_r <= kval_s1_r;
         // multi-bit pins may skew by a cycle; a level settles next sample
         user_r    <= kval_s2_r ? knob_s2_r : user_s2_r;
      end
   end

   blc_reply_tx u_tx
   (
      .clk_in       (clk_in),
      .rstn_in      (rstn_in),
      .req          (rep.snk),
      .tx_byte_out  (tx_byte_out),
      .tx_valid_out (tx_valid_out),
      .tx_ready_in  (tx_ready_in)
   );

   // no range check on global vs floor/ceiling: left to the host
   blc_bright_calc u_calc
   (
      .clk_in           (clk_in),
      .rstn_in          (rstn_in),
      .floor_in         (floor_r),
      .ceiling_in       (ceiling_r),
      .global_in        (global_r),
      .user_in          (user_r),
      .keypad_in        (keypad_r),
      .follow_sel_in    (keypad_follow_select_in),
      .visible_out      (visible_backlight_out),
      .keypad_drive_out (keypad_led_drive_out)
   );

   assign store_strobe_out           = store_r;
   assign store_floor_out            = floor_r;
   assign store_ceiling_out          = ceiling_r;
   assign store_keypad_out           = keypad_r;
   assign backlight_floor_out        = floor_r;
   assign backlight_ceiling_out      = ceiling_r;
   assign backlight_global_level_out = global_r;
   assign backlight_user_level_out   = user_r;
   assign keypad_led_level_out       = keypad_r;
endmodule : blc_backlight_cmd

// file: tb/blc_backlight_cmd_checker.sv
// port checker of the brightness command handler
// assumes bind onto blc_backlight_cmd, single clock domain
`timescale 1ns/100ps
module blc_backlight_cmd_checker
(
   // inputs
   input wire logic       clk_in,
   input wire logic       rstn_in,
   input wire logic       rx_valid_in,
   input wire logic       tx_ready_in,
   input wire logic [7:0] keypad_follow_select_in,
   // outputs
   input wire logic [7:0] tx_byte_out,
   input wire logic       tx_valid_out,
   input wire logic       store_strobe_out,
   input wire logic [7:0] backlight_floor_out,
   input wire logic [7:0] backlight_ceiling_out,
   input wire logic [7:0] backlight_global_level_out,
   input wire logic [7:0] keypad_led_level_out,
   input wire logic [7:0] visible_backlight_out,
   input wire logic [7:0] keypad_led_drive_out
);
   logic [1:0] age_r;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // skips the load cycle, where global is legally reloaded
   always_ff @(posedge clk_in or negedge rstn_in)
      if (!rstn_in)
         age_r <= 2'h0;
      else if (age_r != 2'h3)
         age_r <= age_r + 2'h1;
   // a stalled reply byte holds until the sink takes it
   property p_hold;
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out);
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte moved");
   property p_lo;
      1'b1 |=> visible_backlight_out >= $past(backlight_floor_out);
   endproperty
   a_lo: assert property (p_lo) else $error("visible below floor");
   property p_hi;
      1'b1 |=> visible_backlight_out <= $past(backlight_ceiling_out)
         || visible_backlight_out == $past(backlight_floor_out);
   endproperty
   a_hi: assert property (p_hi) else $error("visible above ceiling");
   property p_kpd;
      keypad_follow_select_in != 8'hFF |=> keypad_led_drive_out == $past(keypad_led_level_out);
   endproperty
   a_kpd: assert property (p_kpd) else $error("keypad drive not level");
   property p_glo;
      age_r[1] && $changed(backlight_global_level_out) |-> $past(rx_valid_in)
         || $past(rx_valid_in, 2) || $past(rx_valid_in, 3) || $past(rx_valid_in, 4);
   endproperty
   a_glo: assert property (p_glo) else $error("global moved without frame");
   property p_sto;
      store_strobe_out |-> $past(rx_valid_in, 2) ##1 !store_strobe_out;
   endproperty
   a_sto: assert property (p_sto) else $error("store strobe wrong");
   property p_lead;
      $rose(tx_valid_out) |-> tx_byte_out == 8'h06 || tx_byte_out == 8'h15;
   endproperty
   a_lead: assert property (p_lead) else $error("reply lead wrong");
   property p_lat;
      $rose(tx_valid_out) |-> $past(rx_valid_in, 2);
   endproperty
   a_lat: assert property (p_lat) else $error("reply latency wrong");
endmodule : blc_backlight_cmd_checker
bind blc_backlight_cmd blc_backlight_cmd_checker u_chk (.clk_in, .rstn_in, .rx_valid_in,
   .tx_ready_in, .keypad_follow_select_in, .tx_byte_out, .tx_valid_out, .store_strobe_out,
   .backlight_floor_out, .backlight_ceiling_out, .backlight_global_level_out,
   .keypad_led_level_out, .visible_backlight_out, .keypad_led_drive_out);

// file: tb/blc_host_model.sv
// host model: sends checked frames, sinks reply bytes
// assumes a one-cycle byte strobe link, no back-pressure on rx
`timescale 1ns/100ps
module blc_host_model
(
   // clock
   input  wire logic       clk_in,
   // frames out
   output logic [7:0]      rx_byte_out,
   output logic            rx_valid_out,
   // replies in
   input  wire logic [7:0] tx_byte_in,
   input  wire logic       tx_valid_in,
   output logic            tx_ready_out
);
   logic [7:0] got[$];
   logic       slow = 1'b0;
   initial
   begin
      rx_byte_out = 8'h00;
      rx_valid_out = 1'b0;
      tx_ready_out = 1'b1;
   end
   // slow mode stalls every other cycle
   always @(posedge clk_in)
   begin
      if (tx_valid_in && tx_ready_out)
         got.push_back(tx_byte_in);
      tx_ready_out <= #1 slow ? ~tx_ready_out : 1'b1;
   end
   task send(input logic [7:0] a, input logic [23:0] c, input logic [7:0] n, d,
             input logic [1:0] bad);
      logic [7:0] f[$];
      logic [7:0] s;
      // bad[0] spoils the header check, bad[1] leads with an ack code
      f = '{bad[1] ? 8'h06 : 8'h07, a, c[23:16], c[15:8], c[7:0], n};
      s = 8'h00;
      foreach (f[i]) s = s + f[i];
      f.push_back(~s ^ {7'h00, bad[0]});
      if (n != 8'h00) f = {f, d, ~d};
      foreach (f[i])
      begin
         @(posedge clk_in);
         #1 rx_byte_out = f[i];
         rx_valid_out = 1'b1;
      end
      @(posedge clk_in);
      // released line shows inverse, not a stale byte
      #1 rx_valid_out = 1'b0;
      rx_byte_out = ~rx_byte_out;
   endtask : send
endmodule : blc_host_model

// file: tb/blc_backlight_cmd_bench.sv
// self-checking bench of the brightness command handler
// assumes host model and bound checker beside the design
`timescale 1ns/100ps
module blc_backlight_cmd_bench;
   logic       clk_in = 1'b0;
   logic       rstn_in = 1'b0;
   logic       rx_valid, tx_valid, tx_ready, sv = 1'b1, kv = 1'b0;
   logic [7:0] rx_byte, tx_byte, fol = 8'h00, fac = 8'h40, usr = 8'h00, knob = 8'hFF;
   logic [7:0] flo, cei, glo, kpl, vis, kpd, usl, sfl, sce, skp;
   int         mismatches = 0, checked = 0;
   always #25 clk_in = ~clk_in;
   blc_host_model u_host (.clk_in, .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
      .tx_byte_in(tx_byte), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));
   blc_backlight_cmd u_dut (.clk_in, .rstn_in, .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
      .tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
      .unit_address_in(8'h05), .keypad_follow_select_in(fol), .factory_global_in(fac),
      .stored_valid_in(sv), .stored_floor_in(8'h11), .stored_ceiling_in(8'hEE),
      .stored_keypad_in(8'h33), .store_strobe_out(), .store_floor_out(sfl),
      .store_ceiling_out(sce), .store_keypad_out(skp), .knob_input_valid_in(kv),
      .knob_level_in(knob), .user_level_in(usr), .backlight_floor_out(flo),
      .backlight_ceiling_out(cei), .backlight_global_level_out(glo),
      .backlight_user_level_out(usl), .keypad_led_level_out(kpl),
      .visible_backlight_out(vis), .keypad_led_drive_out(kpd));
   task chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task do_reset(input logic v);
      #1 rstn_in = 1'b0;
      sv = v;
      repeat (3) @(posedge clk_in);
      #1 rstn_in = 1'b1;
      repeat (3) @(posedge clk_in);
      #1;
   endtask : do_reset
   task reply(input logic [7:0] ld, a, input logic [23:0] c, input logic [7:0] n, d);
      logic [7:0] e[$];
      logic [7:0] s;
      e = '{ld, a, c[23:16], c[15:8], c[7:0], n};
      s = 8'h00;
      foreach (e[i]) s = s + e[i];
      e.push_back(~s);
      if (n != 8'h00) e = {e, d, ~d};
      for (int k = 0; k < 200 && u_host.got.size() < e.size(); k++) @(posedge clk_in);
      foreach (e[i]) chk(u_host.got[i], e[i]);
      u_host.got.delete();
   endtask : reply
   task wr(input logic [23:0] c, input logic [7:0] d, q);
      u_host.send(8'hFF, c, 8'h01, d, 1'b0);
      reply(8'h06, 8'hFF, c, 8'h01, q);
   endtask : wr
   task rd(input logic [7:0] c, d);
      u_host.send(8'hFF, {16'h4252, c}, 8'h00, 8'h00, 1'b0);
      reply(8'h06, 8'hFF, {16'h4252, c}, 8'h01, d);
   endtask : rd
   task t_load;
      chk({flo, cei, kpl, glo}, 32'h11EE_3340);
      do_reset(1'b0);
      chk({flo, cei, kpl, glo}, 32'hFFFF_FF40);
   endtask : t_load
   task t_rw;
      wr(24'h42_5249, 8'h20, 8'h20);
      wr(24'h42_524D, 8'hE0, 8'hE0);
      wr(24'h42_524C, 8'h5A, 8'h5A);
      wr(24'h42_5254, 8'h99, 8'h99);
      chk({flo, cei, kpl, glo}, 32'h20E0_5A99);
      chk({sfl, sce, skp}, 24'h20_E05A);
      u_host.slow = 1'b1;
      rd(8'h49, 8'h20);
      rd(8'h4D, 8'hE0);
      rd(8'h4C, 8'h5A);
      rd(8'h54, 8'h99);
      u_host.slow = 1'b0;
   endtask : t_rw
   task t_bad;
      u_host.send(8'h05, 24'h42_5249, 8'h01, 8'h77, 1'b1);
      reply(8'h15, 8'h05, 24'h42_5249, 8'h00, 8'h00);
      u_host.send(8'h05, 24'h42_5249, 8'h01, 8'h30, 2'h2);
      repeat (20) @(posedge clk_in);
      chk(u_host.got.size(), 0);
      chk(flo, 8'h20);
   endtask : t_bad
   task t_vis;
      #1 usr = 8'h80;
      repeat (8) @(posedge clk_in);
      chk({vis, glo, kpd, usl}, 32'h5C99_5A80);
      #1 kv = 1'b1;
      fol = 8'hFF;
      repeat (8) @(posedge clk_in);
      chk({vis, glo, kpd, usl}, 32'h9999_99FF);
      wr(24'h42_524D, 8'h80, 8'h80);
      chk(vis, 8'h80);
   endtask : t_vis
   task t_menu;
      wr(24'h4D_4343, 8'h2B, 8'h9A);
      wr(24'h4D_4343, 8'h2D, 8'h99);
      wr(24'h4D_4343, 8'h3F, 8'h99);
      wr(24'h4D_4343, 8'h72, fac);
      wr(24'h4D_4343, 8'h52, fac);
      chk({flo, cei, kpl, glo}, 32'hFFFF_FF40);
   endtask : t_menu
   task finish_test;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // far beyond the few hundred cycles the tests need
   initial
   begin
      #2000000;
      mismatches++;
      finish_test;
   end
   initial
   begin
      do_reset(1'b1);
      t_load;
      t_rw;
      t_bad;
      t_vis;
      t_menu;
      finish_test;
   end
endmodule : blc_backlight_cmd_bench
